// *** src/drive_status_output.v ***
// Status signal generator: frequency, overload, loss, limit and life flags onto terminals and relay
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "drive_status_regs.vh"

module drive_status_output #(
  parameter TICK_CYCLES = `TICK_MS * (`SYS_CLK_HZ / 1000),
  parameter TL_DELAY_CYCLES = `TL_DELAY_MS * (`SYS_CLK_HZ / 1000),
  parameter POWER_ON_CYCLES = `POWER_ON_MS * (`SYS_CLK_HZ / 1000)
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [15:0] out_freq_i,
  input wire [15:0] set_freq_i,
  input wire [15:0] out_current_i,
  input wire [15:0] analog_current_input_i,
  input wire limit_active_i,
  input wire running_i,
  input wire drive_ready_i,
  input wire motor2_sel_i,
  input wire [15:0] main_cap_life_data_i,
  input wire [16:0] board_cap_life_data_i,
  input wire [16:0] fan_life_data_i,
  output wire freq_arrival_out_o,
  output wire freq_detect1_out_o,
  output wire freq_detect2_out_o,
  output wire overload_warn1_out_o,
  output wire overload_warn2_out_o,
  output wire current_input_loss_out_o,
  output wire torque_limit_delayed_out_o,
  output wire life_warning_out_o,
  output wire [3:0] term_out_o,
  output wire relay_contact_closed_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [7:0] ctrl_q;
  reg [15:0] arrival_hyst_q;
  reg [15:0] detect1_level_q;
  reg [15:0] detect_hyst_q;
  reg [15:0] overload1_level_q;
  reg [15:0] overload_timer_q;
  reg [15:0] detect2_level_q;
  reg [15:0] overload2_level_q;
  reg [24:0] term_sel_q;
  reg arr_q;
  reg det1_q;
  reg det2_q;
  reg c1off_q;
  reg life_q;
  reg tld_q;
  reg warn1_q;
  reg ctl_ready_q;
  reg [3:0] term_q;
  reg relay_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [31:0] tl_cnt_q;
  reg [31:0] pon_cnt_q;
  reg [31:0] rd_data;
  reg addr_ok;
  wire wr_en;
  wire warn1_cur;
  wire warn1_th;
  wire warn2;
  wire [15:0] sig_vec;
  wire sig5;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Limits a written value to a setting range
  function [15:0] clamp16;
    input [31:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < {16'h0000, lo}) begin
        clamp16 = lo;
      end else if (v > {16'h0000, hi}) begin
        clamp16 = hi;
      end else begin
        clamp16 = v[15:0];
      end
    end
  endfunction

  // Level detector with release hysteresis; keeps state in between
  function detect_hyst;
    input state;
    input [15:0] freq;
    input [15:0] level;
    input [15:0] hyst;
    begin
      if (freq > level) begin
        detect_hyst = 1'b1;
      end else if ({1'b0, freq} + {1'b0, hyst} <= {1'b0, level}) begin
        detect_hyst = 1'b0;
      end else begin
        detect_hyst = state;
      end
    end
  endfunction

  // Picks the signal for a terminal selection code; unknown codes give OFF
  function pick_sig;
    input [4:0] code;
    input [15:0] sigs;
    begin
      pick_sig = code[4] ? 1'b0 : sigs[code[3:0]];
    end
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------

  // Writes take effect at the edge where pready is seen high
  assign wr_en = psel_i && penable_i && pwrite_i && pready_q && !pslverr_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // Read mux and address decode
  always @* begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr_i)
      `OFF_CTRL: rd_data = {24'h000000, ctrl_q};
      `OFF_ARRIVAL_HYST: rd_data = {16'h0000, arrival_hyst_q};
      `OFF_DETECT1_LEVEL: rd_data = {16'h0000, detect1_level_q};
      `OFF_DETECT_HYST: rd_data = {16'h0000, detect_hyst_q};
      `OFF_OVERLOAD1_LEVEL: rd_data = {16'h0000, overload1_level_q};
      `OFF_OVERLOAD_TIMER: rd_data = {16'h0000, overload_timer_q};
      `OFF_DETECT2_LEVEL: rd_data = {16'h0000, detect2_level_q};
      `OFF_OVERLOAD2_LEVEL: rd_data = {16'h0000, overload2_level_q};
      `OFF_TERM_SEL: rd_data = {7'h00, term_sel_q};
      `OFF_STATUS: rd_data = {22'h000000, ctl_ready_q, relay_q, life_q, tld_q, c1off_q,
                              warn2, warn1_q, det2_q, det1_q, arr_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: answer is registered in the first access cycle
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_ok;
      prdata_q <= pwrite_i ? 32'h00000000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------

  // Written level, hysteresis and timer values are limited to their setting ranges
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `RST_CTRL;
      arrival_hyst_q <= `RST_ARRIVAL_HYST;
      detect1_level_q <= `RST_DETECT1_LEVEL;
      detect_hyst_q <= `RST_DETECT_HYST;
      overload1_level_q <= `RST_OVERLOAD_LEVEL;
      overload_timer_q <= `RST_OVERLOAD_TIMER;
      detect2_level_q <= `RST_DETECT1_LEVEL;
      overload2_level_q <= `RST_OVERLOAD_LEVEL;
      term_sel_q <= `RST_TERM_SEL;
    end else if (wr_en) begin
      case (paddr_i)
        `OFF_CTRL: ctrl_q <= {pwdata_i[7:4], 2'b00, pwdata_i[1:0]};
        `OFF_ARRIVAL_HYST: arrival_hyst_q <= clamp16(pwdata_i, 16'h0000, `MAX_ARRIVAL_HYST);
        `OFF_DETECT1_LEVEL: detect1_level_q <= clamp16(pwdata_i, 16'h0000, `MAX_FREQ_LEVEL);
        `OFF_DETECT_HYST: detect_hyst_q <= clamp16(pwdata_i, 16'h0000, `MAX_DETECT_HYST);
        `OFF_OVERLOAD1_LEVEL: overload1_level_q <= clamp16(pwdata_i, `MIN_OVERLOAD_LEVEL,
                                                           `MAX_OVERLOAD_LEVEL);
        `OFF_OVERLOAD_TIMER: overload_timer_q <= clamp16(pwdata_i, `MIN_OVERLOAD_TIMER,
                                                         `MAX_OVERLOAD_TIMER);
        `OFF_DETECT2_LEVEL: detect2_level_q <= clamp16(pwdata_i, 16'h0000, `MAX_FREQ_LEVEL);
        `OFF_OVERLOAD2_LEVEL: overload2_level_q <= clamp16(pwdata_i, `MIN_OVERLOAD_LEVEL,
                                                           `MAX_OVERLOAD_LEVEL);
        `OFF_TERM_SEL: term_sel_q <= pwdata_i[24:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------

  // 100 ms tick for the overload timer and thermal model
  always @(posedge sys_clk_i) begin
    if (srst_i || tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  // Tick pulse, one cycle long
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == TICK_CYCLES - 1;
    end
  end

  // Control voltage settles a fixed time after reset release
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      pon_cnt_q <= 32'h00000000;
      ctl_ready_q <= 1'b0;
    end else if (pon_cnt_q == POWER_ON_CYCLES - 1) begin
      ctl_ready_q <= 1'b1;
    end else begin
      pon_cnt_q <= pon_cnt_q + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Frequency, input loss and life flags
  // ----------------------------------------

  // Compared every cycle against the newest samples
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      arr_q <= 1'b0;
      det1_q <= 1'b0;
      det2_q <= 1'b0;
      warn1_q <= 1'b0;
      c1off_q <= 1'b0;
      life_q <= 1'b0;
    end else begin
      arr_q <= ({1'b0, out_freq_i} + {1'b0, arrival_hyst_q} >= {1'b0, set_freq_i}) &&
               ({1'b0, set_freq_i} + {1'b0, arrival_hyst_q} >= {1'b0, out_freq_i});
      det1_q <= detect_hyst(det1_q, out_freq_i, detect1_level_q, detect_hyst_q);
      det2_q <= detect_hyst(det2_q, out_freq_i, detect2_level_q, detect_hyst_q);
      warn1_q <= ctrl_q[`CTRL_MODE_BIT] ? warn1_cur : warn1_th;
      c1off_q <= analog_current_input_i < `CURRENT_LOSS_LIMIT;
      // Life flag only drives its output, the terminals, the relay and the status word; it raises no alarm
      life_q <= main_cap_life_data_i <= `MAIN_CAP_LIMIT ||
                board_cap_life_data_i >= `BOARD_CAP_HOURS ||
                fan_life_data_i >= `FAN_HOURS;
    end
  end

  // ----------------------------------------
  // Delayed limiting flag
  // ----------------------------------------

  // Counter restarts whenever limiting stops
  always @(posedge sys_clk_i) begin
    if (srst_i || !limit_active_i) begin
      tl_cnt_q <= 32'h00000000;
      tld_q <= 1'b0;
    end else if (tl_cnt_q == TL_DELAY_CYCLES - 1) begin
      tld_q <= 1'b1;
    end else begin
      tl_cnt_q <= tl_cnt_q + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Overload warnings
  // ----------------------------------------

  // Current mode of warning one, motor 1 only
  level_timer #(
    .VW(16),
    .TW(16)
  ) u_warn1_cur (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .enable_i(!motor2_sel_i && ctrl_q[`CTRL_MODE_BIT]),
    .tick_i(tick_q),
    .value_i(out_current_i),
    .level_i(overload1_level_q),
    .delay_i(overload_timer_q),
    .warn_o(warn1_cur)
  );

  // Thermal mode of warning one, motor 1 only
  thermal_model u_warn1_th (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .enable_i(!motor2_sel_i && !ctrl_q[`CTRL_MODE_BIT]),
    .tick_i(tick_q),
    .current_i(out_current_i),
    .level_i(overload1_level_q),
    .shift_i(ctrl_q[`CTRL_SHIFT_LSB+3:`CTRL_SHIFT_LSB]),
    .warn_o(warn1_th)
  );

  // Warning two ignores the motor selection
  level_timer #(
    .VW(16),
    .TW(16)
  ) u_warn2 (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .enable_i(1'b1),
    .tick_i(tick_q),
    .value_i(out_current_i),
    .level_i(overload2_level_q),
    .delay_i(overload_timer_q),
    .warn_o(warn2)
  );

  // ----------------------------------------
  // Terminal assignment and relay
  // ----------------------------------------

  // Selection codes: 0 run, 1 arrival, 2 detect1, 3 detect2, 7 warn1,
  // 8 warn2, 9 input loss, 10 ready, 11 delayed limit, 12 life, 13 limit
  assign sig_vec = {2'b00, limit_active_i, life_q, tld_q, drive_ready_i, c1off_q, warn2,
                    warn1_q, 3'b000, det2_q, det1_q, arr_q, running_i};
  assign sig5 = pick_sig(term_sel_q[24:20], sig_vec);

  // Terminals and relay updated every cycle
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      term_q <= 4'h0;
      relay_q <= 1'b0;
    end else begin
      term_q <= {pick_sig(term_sel_q[19:15], sig_vec), pick_sig(term_sel_q[14:10], sig_vec),
                 pick_sig(term_sel_q[9:5], sig_vec), pick_sig(term_sel_q[4:0], sig_vec)};
      // Relay stays open until control voltage is up
      relay_q <= ctl_ready_q && (sig5 ^ ctrl_q[`CTRL_POLARITY_BIT]);
    end
  end

  // ----------------------------------------
  // Flag outputs
  // ----------------------------------------
  assign freq_arrival_out_o = arr_q;
  assign freq_detect1_out_o = det1_q;
  assign freq_detect2_out_o = det2_q;
  assign overload_warn1_out_o = warn1_q;
  assign overload_warn2_out_o = warn2;
  assign current_input_loss_out_o = c1off_q;
  assign torque_limit_delayed_out_o = tld_q;
  assign life_warning_out_o = life_q;
  assign term_out_o = term_q;
  assign relay_contact_closed_o = relay_q;
endmodule

// *** src/drive_status_regs.vh ***
// Register map, field layout, reset values, limits and timing of the drive status outputs
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_HZ 100000000
`define TICK_MS 100
`define TL_DELAY_MS 20
`define POWER_ON_MS 1000

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_ARRIVAL_HYST 8'h04
`define OFF_DETECT1_LEVEL 8'h08
`define OFF_DETECT_HYST 8'h0C
`define OFF_OVERLOAD1_LEVEL 8'h10
`define OFF_OVERLOAD_TIMER 8'h14
`define OFF_DETECT2_LEVEL 8'h18
`define OFF_OVERLOAD2_LEVEL 8'h1C
`define OFF_TERM_SEL 8'h20
`define OFF_STATUS 8'h24

// ----------------------------------------
// Fields: CTRL and TERM_SEL
// ----------------------------------------
`define CTRL_POLARITY_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_SHIFT_LSB 4
`define TERM_SEL_W 5

// ----------------------------------------
// Reset values and setting limits (0.1 Hz, 0.1 %, 0.1 s units)
// ----------------------------------------
`define RST_CTRL 8'h50
`define RST_ARRIVAL_HYST 16'h0019
`define RST_DETECT1_LEVEL 16'h0258
`define RST_DETECT_HYST 16'h000A
`define RST_OVERLOAD_LEVEL 16'h03E8
`define RST_OVERLOAD_TIMER 16'h000A
`define RST_TERM_SEL 25'h0A38820
`define MAX_ARRIVAL_HYST 16'h0064
`define MAX_FREQ_LEVEL 16'h04B0
`define MAX_DETECT_HYST 16'h012C
`define MIN_OVERLOAD_LEVEL 16'h0032
`define MAX_OVERLOAD_LEVEL 16'h05DC
`define MIN_OVERLOAD_TIMER 16'h0001
`define MAX_OVERLOAD_TIMER 16'h0258

// ----------------------------------------
// Judgment levels (0.1 %, hours, 0.01 mA)
// ----------------------------------------
`define MAIN_CAP_LIMIT 16'h0352
`define BOARD_CAP_HOURS 17'h0EE48
`define FAN_HOURS 17'h061A8
`define CURRENT_LOSS_LIMIT 16'h00C8

`endif

// *** src/level_timer.v ***
// Current level warning with delay timer and 90 percent release level
`timescale 1ns/1ps
`include "drive_status_regs.vh"

module level_timer #(
  parameter VW = 16,
  parameter TW = 16
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire enable_i,
  input wire tick_i,
  input wire [VW-1:0] value_i,
  input wire [VW-1:0] level_i,
  input wire [TW-1:0] delay_i,
  output reg warn_o
);
  reg [TW-1:0] cnt_q;
  wire [VW+3:0] value_x10;
  wire [VW+3:0] level_x9;
  wire above;

  // Release compares value*10 against level*9 to avoid a divider
  assign value_x10 = ({4'h0, value_i} << 3) + ({4'h0, value_i} << 1);
  assign level_x9 = ({4'h0, level_i} << 3) + {4'h0, level_i};
  assign above = value_i > level_i;

  // Timer restarts whenever the current drops to the level or below
  always @(posedge sys_clk_i) begin
    if (srst_i || !enable_i || !above) begin
      cnt_q <= {TW{1'b0}};
    end else if (tick_i && cnt_q != delay_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Set after the delay, clear below 90 percent of the level or when disabled
  always @(posedge sys_clk_i) begin
    if (srst_i || !enable_i) begin
      warn_o <= 1'b0;
    end else if (above && cnt_q == delay_i) begin
      warn_o <= 1'b1;
    end else if (value_x10 < level_x9) begin
      warn_o <= 1'b0;
    end
  end
endmodule

// *** src/thermal_model.v ***
// Inverse-time thermal overload model for the first overload warning
`timescale 1ns/1ps
`include "drive_status_regs.vh"

module thermal_model (
  input wire sys_clk_i,
  input wire srst_i,
  input wire enable_i,
  input wire tick_i,
  input wire [15:0] current_i,
  input wire [15:0] level_i,
  input wire [3:0] shift_i,
  output reg warn_o
);
  reg [47:0] heat_q;
  wire [31:0] cur_sq;
  wire [31:0] lvl_sq;
  wire [31:0] rel_sq;
  wire [19:0] rel_lvl;
  wire [47:0] trip_at;
  wire [47:0] release_at;

  // Heat settles at current squared times 2^shift ticks
  assign cur_sq = current_i * current_i;
  assign lvl_sq = level_i * level_i;
  assign rel_lvl = ({4'h0, level_i} * 20'h00009) / 20'h0000A;
  assign rel_sq = rel_lvl[15:0] * rel_lvl[15:0];
  assign trip_at = {16'h0000, lvl_sq} << shift_i;
  assign release_at = {16'h0000, rel_sq} << shift_i;

  // Leaky integrator, one step per tick
  always @(posedge sys_clk_i) begin
    if (srst_i || !enable_i) begin
      heat_q <= 48'h000000000000;
    end else if (tick_i) begin
      heat_q <= heat_q + {16'h0000, cur_sq} - (heat_q >> shift_i);
    end
  end

  // Equivalent-current warning with 90 percent release
  always @(posedge sys_clk_i) begin
    if (srst_i || !enable_i) begin
      warn_o <= 1'b0;
    end else if (heat_q >= trip_at) begin
      warn_o <= 1'b1;
    end else if (heat_q < release_at) begin
      warn_o <= 1'b0;
    end
  end
endmodule

// *** test/terminal_reader.sv ***
// Controller model that scans the four status terminals and the relay contact
`timescale 1ns/1ps
module terminal_reader (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [3:0] term_i,
  input wire relay_closed_i,
  output logic [4:0] seen_o
);
  // Latches the pins once a clock, like an input card
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      seen_o <= 5'h00;
    end else begin
      seen_o <= {relay_closed_i, term_i};
    end
  end
endmodule

// *** test/drive_status_output_asserts.sv ***
// Port-level checks of the drive status output block
`timescale 1ns/1ps
module drive_status_output_asserts #(
  parameter TL_DELAY_CYCLES = 20,
  parameter POWER_ON_CYCLES = 50
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [15:0] analog_current_input_i,
  input wire limit_active_i,
  input wire [15:0] main_cap_life_data_i,
  input wire [16:0] board_cap_life_data_i,
  input wire [16:0] fan_life_data_i,
  input wire current_input_loss_out_o,
  input wire torque_limit_delayed_out_o,
  input wire life_warning_out_o,
  input wire [3:0] term_out_o,
  input wire relay_contact_closed_o
);
  int lim_q;
  int pwr_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Unbroken limiting edges, and edges since reset release
  always @(posedge sys_clk_i) begin
    lim_q <= (srst_i || !limit_active_i) ? 0 : lim_q + 1;
    pwr_q <= srst_i ? 0 : ((pwr_q < POWER_ON_CYCLES) ? pwr_q + 1 : pwr_q);
  end
  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  sequence s_taken;
    psel_i && penable_i && !pready_o;
  endsequence
  AST_APB_ANSWER: assert property (s_taken |=> pready_o) else $error("no ready after access");
  AST_APB_PULSE: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  AST_APB_MISALIGN: assert property (s_taken ##0 (paddr_i[1:0] != 2'h0) |=> pslverr_o)
    else $error("misaligned access not refused");
  // ----------------------------------------
  // Flags
  // ----------------------------------------
  AST_LOSS_FLAG: assert property (!$past(srst_i) |->
    current_input_loss_out_o == ($past(analog_current_input_i) < 16'h00C8)) else $error("loss flag wrong");
  AST_LIFE_FLAG: assert property (!$past(srst_i) |-> life_warning_out_o ==
    ($past(main_cap_life_data_i) <= 16'h0352 || $past(board_cap_life_data_i) >= 17'h0EE48 ||
    $past(fan_life_data_i) >= 17'h061A8)) else $error("life flag wrong");
  AST_TL_MIN: assert property ($rose(torque_limit_delayed_out_o) |-> lim_q >= TL_DELAY_CYCLES)
    else $error("delayed limit flag too early");
  AST_TL_RISE: assert property (lim_q == TL_DELAY_CYCLES + 2 |-> torque_limit_delayed_out_o)
    else $error("delayed limit flag missing");
  AST_TL_DROP: assert property ($fell(limit_active_i) |=> !torque_limit_delayed_out_o)
    else $error("delayed limit flag not dropped");
  AST_RELAY_HOLD: assert property (pwr_q < POWER_ON_CYCLES |-> !relay_contact_closed_o)
    else $error("relay closed before control ready");
  AST_RESET_QUIET: assert property ($past(srst_i) |-> !current_input_loss_out_o && !life_warning_out_o &&
    !torque_limit_delayed_out_o && term_out_o == 4'h0 && !relay_contact_closed_o && !pready_o)
    else $error("outputs active after reset");
endmodule
bind drive_status_output drive_status_output_asserts #(
  .TL_DELAY_CYCLES(TL_DELAY_CYCLES),
  .POWER_ON_CYCLES(POWER_ON_CYCLES)
) i_drive_status_output_asserts (.*);

// *** test/test_drive_status_output.sv ***
// Self-checking bench for the drive status output block
`timescale 1ns/1ps
`include "drive_status_regs.vh"
module test_drive_status_output;
  typedef struct {
    logic [15:0] f, s, a, m;
    logic [16:0] b, n;
    logic run, rdy;
    logic [4:0] flags;
  } row_t;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, limit_active_i = 1'b0;
  logic running_i = 1'b0, drive_ready_i = 1'b0, motor2_sel_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [15:0] out_freq_i = 16'h0000, set_freq_i = 16'h0000, out_current_i = 16'h0000;
  logic [15:0] analog_current_input_i = 16'h03E8, main_cap_life_data_i = 16'h03E8;
  logic [16:0] board_cap_life_data_i = 17'h00000, fan_life_data_i = 17'h00000;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, freq_arrival_out_o, freq_detect1_out_o, freq_detect2_out_o, overload_warn1_out_o;
  wire overload_warn2_out_o, current_input_loss_out_o, torque_limit_delayed_out_o, life_warning_out_o;
  wire relay_contact_closed_o;
  wire [3:0] term_out_o;
  wire [4:0] seen;
  int miscompares = 0, total_checks = 0, cycles = 0;
  // Rows: freq, set, analog, main cap, board cap, fan, run, ready, {life, loss, det2, det1, arrival}
  row_t rows[7] = '{
    '{16'h01F4, 16'h01F4, 16'h03E8, 16'h03E8, 17'h00000, 17'h00000, 1'b1, 1'b1, 5'h01},
    '{16'h0259, 16'h0240, 16'h00C8, 16'h03E8, 17'h00000, 17'h00000, 1'b0, 1'b0, 5'h07},
    '{16'h024F, 16'h026C, 16'h00C7, 16'h03E8, 17'h00000, 17'h00000, 1'b1, 1'b1, 5'h0E},
    '{16'h024E, 16'h024E, 16'h03E8, 16'h0352, 17'h00000, 17'h00000, 1'b0, 1'b1, 5'h11},
    '{16'h0258, 16'h0258, 16'h03E8, 16'h0353, 17'h0EE48, 17'h00000, 1'b1, 1'b0, 5'h11},
    '{16'h0258, 16'h0258, 16'h03E8, 16'h0353, 17'h0EE47, 17'h061A8, 1'b0, 1'b1, 5'h11},
    '{16'h0258, 16'h0258, 16'h03E8, 16'h0353, 17'h0EE47, 17'h061A7, 1'b1, 1'b0, 5'h01}};

  drive_status_output #(.TICK_CYCLES(10), .TL_DELAY_CYCLES(20), .POWER_ON_CYCLES(50)) i_drive_status_output (.*);
  terminal_reader i_terminal_reader (.sys_clk_i, .srst_i, .term_i(term_out_o),
    .relay_closed_i(relay_contact_closed_o), .seen_o(seen));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard far above the run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits n edges, then steps off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // One bus transfer: setup, access held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check_word("read data", exp, q);
    check_bit("slave error", exp_err, e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Reset values, then an unmapped and a misaligned place
    rd_chk(`OFF_CTRL, 32'h00000050, 1'b0);
    rd_chk(`OFF_TERM_SEL, 32'h00A38820, 1'b0);
    rd_chk(8'h28, 32'h00000000, 1'b1);
    rd_chk(8'h05, 32'h00000000, 1'b1);
    // Inverted relay stays open until control voltage is up
    wr(`OFF_CTRL, 32'h00000051);
    settle(1);
    check_bit("relay early", 1'b0, relay_contact_closed_o);
    settle(60);
    check_bit("relay inverted off", 1'b1, relay_contact_closed_o);
    @(posedge sys_clk_i);
    drive_ready_i <= 1'b1;
    settle(6);
    check_bit("relay inverted on", 1'b0, relay_contact_closed_o);
    wr(`OFF_CTRL, 32'h00000050);
    // Steady input sets from the table
    foreach (rows[i]) begin
      @(posedge sys_clk_i);
      out_freq_i <= rows[i].f;
      set_freq_i <= rows[i].s;
      analog_current_input_i <= rows[i].a;
      main_cap_life_data_i <= rows[i].m;
      board_cap_life_data_i <= rows[i].b;
      fan_life_data_i <= rows[i].n;
      running_i <= rows[i].run;
      drive_ready_i <= rows[i].rdy;
      settle(6);
      check_word("flags", {27'h0, rows[i].flags}, {27'h0, life_warning_out_o, current_input_loss_out_o,
        freq_detect2_out_o, freq_detect1_out_o, freq_arrival_out_o});
      check_word("terminals", {27'h0, rows[i].rdy, 1'b0, rows[i].flags[1:0], rows[i].run},
        {27'h0, seen});
    end
    // Settings are clamped into range
    wr(`OFF_DETECT1_LEVEL, 32'h0000FFFF);
    rd_chk(`OFF_DETECT1_LEVEL, 32'h000004B0, 1'b0);
    wr(`OFF_OVERLOAD1_LEVEL, 32'h00000000);
    rd_chk(`OFF_OVERLOAD1_LEVEL, 32'h00000032, 1'b0);
    wr(`OFF_OVERLOAD1_LEVEL, 32'h000003E8);
    // Thermal warning one at twice the level, heat builds over ticks
    @(posedge sys_clk_i);
    out_current_i <= 16'h07D0;
    settle(150);
    check_bit("thermal warning", 1'b1, overload_warn1_out_o);
    @(posedge sys_clk_i);
    out_current_i <= 16'h0000;
    // Current-mode overload with motor selection and release level
    wr(`OFF_CTRL, 32'h00000052);
    wr(`OFF_OVERLOAD_TIMER, 32'h00000002);
    @(posedge sys_clk_i);
    motor2_sel_i <= 1'b1;
    out_current_i <= 16'h03E9;
    settle(8);
    check_bit("overload two early", 1'b0, overload_warn2_out_o);
    settle(25);
    check_bit("overload two", 1'b1, overload_warn2_out_o);
    check_bit("overload one on motor two", 1'b0, overload_warn1_out_o);
    @(posedge sys_clk_i);
    motor2_sel_i <= 1'b0;
    settle(30);
    check_bit("overload one", 1'b1, overload_warn1_out_o);
    @(posedge sys_clk_i);
    out_current_i <= 16'h0385;
    settle(5);
    check_bit("overload hold", 1'b1, overload_warn2_out_o);
    @(posedge sys_clk_i);
    out_current_i <= 16'h0383;
    settle(4);
    check_bit("overload two release", 1'b0, overload_warn2_out_o);
    check_bit("overload one release", 1'b0, overload_warn1_out_o);
    // Short excursions must not add up
    repeat (2) begin
      @(posedge sys_clk_i);
      out_current_i <= 16'h03E9;
      settle(6);
      check_bit("overload restart", 1'b0, overload_warn2_out_o);
      @(posedge sys_clk_i);
      out_current_i <= 16'h03E8;
    end
    wr(`OFF_TERM_SEL, 32'h00A3882B);
    // Delayed limit flag: broken run, full run, drop
    @(posedge sys_clk_i);
    limit_active_i <= 1'b1;
    settle(15);
    check_bit("limit early", 1'b0, torque_limit_delayed_out_o);
    @(posedge sys_clk_i);
    limit_active_i <= 1'b0;
    @(posedge sys_clk_i);
    limit_active_i <= 1'b1;
    settle(25);
    check_bit("limit delayed", 1'b1, torque_limit_delayed_out_o);
    check_bit("delayed limit terminal", 1'b1, seen[0]);
    rd_chk(`OFF_STATUS, 32'h00000241, 1'b0);
    @(posedge sys_clk_i);
    limit_active_i <= 1'b0;
    settle(2);
    check_bit("limit dropped", 1'b0, torque_limit_delayed_out_o);
    end_of_test();
  end
endmodule
